// file: core/bcs_pkg.sv
package bcs_pkg;
    // Register byte addresses in ISA I/O space
    localparam logic [15:0] BCS_ADDR_PROC_CFG   = 16'h0800;
    localparam logic [15:0] BCS_ADDR_JUMPERS    = 16'h0801;
    localparam logic [15:0] BCS_ADDR_BOARD_OPT  = 16'h0802;
    localparam logic [15:0] BCS_ADDR_DRAM_SIZE  = 16'h0804;
    // Processor type code, value is arbitrary
    localparam logic [3:0]  BCS_PROC_KIND_CODE  = 4'hA;
    // Field positions of the processor configuration byte
    localparam int          BCS_CACHE_LSB       = 0;
    localparam int          BCS_CLOCK_LSB       = 2;
    localparam int          BCS_KIND_LSB        = 4;
    // Board option byte: unused bit position and its fixed value
    localparam int          BCS_OPT_SPARE_BIT   = 5;
    localparam logic        BCS_OPT_SPARE_VAL   = 1'b1;
    // Encodings
    localparam logic [1:0]  BCS_CACHE_512K      = 2'h0;
    localparam logic [1:0]  BCS_CACHE_256K      = 2'h1;
    localparam logic [1:0]  BCS_CACHE_1M        = 2'h2;
    localparam logic [1:0]  BCS_CACHE_NONE      = 2'h3;
    localparam logic [1:0]  BCS_CLK_33_33       = 2'h0;
    localparam logic [1:0]  BCS_CLK_20_40       = 2'h1;
    localparam logic [1:0]  BCS_CLK_25_50       = 2'h2;
    localparam logic [1:0]  BCS_CLK_33_66       = 2'h3;
    localparam logic [1:0]  BCS_BANK_128M       = 2'h0;
    localparam logic [1:0]  BCS_BANK_32M        = 2'h1;
    localparam logic [1:0]  BCS_BANK_8M         = 2'h2;
    localparam logic [1:0]  BCS_BANK_NONE       = 2'h3;
    // Read data shown when nothing is selected
    localparam logic [7:0]  BCS_IDLE_DATA       = 8'h00;
    // Bus access states
    typedef enum logic [1:0] {
        BCS_IDLE = 2'b01,
        BCS_READ = 2'b10
    } bcs_state_t;
endpackage

// file: core/bcs_sync.sv
`timescale 1ns/1ns
// Registers a strap group once per clock; straps are static, one stage suffices
module bcs_sync
    import bcs_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    // Reset to all ones, the absent level of active-low flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end
endmodule

// file: core/bcs_regs.sv
`timescale 1ns/1ns
module bcs_regs
    import bcs_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        RESET_N,
    input  wire logic [15:0] IO_ADDR,
    input  wire logic        IO_READ_N,
    input  wire logic        IO_WRITE_N,
    input  wire logic [1:0]  SECOND_LEVEL_CACHE_SIZE,
    input  wire logic [1:0]  CLOCK_RATIO_CODE,
    input  wire logic [7:0]  JUMPER_HEADER_BITS,
    input  wire logic        TRANSITION_MODULE_ABSENT,
    input  wire logic        SYNC_SERIAL_ABSENT,
    input  wire logic        MEZZANINE_CARD_ABSENT,
    input  wire logic        BACKPLANE_IF_ABSENT,
    input  wire logic        GRAPHICS_ABSENT,
    input  wire logic        NETWORK_ABSENT,
    input  wire logic        DISK_IF_ABSENT,
    input  wire logic [2:0]  BANK_SIZE_CODE_LO,
    input  wire logic        REFRESH_FLAG_N_A_LO,
    input  wire logic [2:0]  BANK_SIZE_CODE_HI,
    input  wire logic        REFRESH_FLAG_N_A_HI,
    output logic      [7:0]  IO_DATA_OUT,
    output logic             IO_DATA_OE
);
    logic [7:0]  opt_raw;
    logic [7:0]  opt_q;
    logic [7:0]  jmp_q;
    logic [7:0]  dram_raw;
    logic [7:0]  dram_q;
    logic [3:0]  cpu_raw;
    logic [3:0]  cpu_q;
    logic [7:0]  proc_cfg;
    logic [7:0]  rd_data_d;
    logic        rd_hit_d;
    bcs_state_t  state_q;
    bcs_state_t  state_d;

    // Gather active-low presence flags in their byte positions
    // active-low flags
    always_comb begin
        opt_raw = 8'hFF;
        opt_raw[7] = TRANSITION_MODULE_ABSENT;
        opt_raw[6] = SYNC_SERIAL_ABSENT;
        opt_raw[BCS_OPT_SPARE_BIT] = BCS_OPT_SPARE_VAL;
        opt_raw[4] = MEZZANINE_CARD_ABSENT;
        opt_raw[3] = BACKPLANE_IF_ABSENT;
        opt_raw[2] = GRAPHICS_ABSENT;
        opt_raw[1] = NETWORK_ABSENT;
        opt_raw[0] = DISK_IF_ABSENT;
    end

    // DRAM pair nibbles: refresh flag on top, size code below
    // pair layout
    assign dram_raw = {REFRESH_FLAG_N_A_HI, BANK_SIZE_CODE_HI,
                       REFRESH_FLAG_N_A_LO, BANK_SIZE_CODE_LO};

    assign cpu_raw = {CLOCK_RATIO_CODE, SECOND_LEVEL_CACHE_SIZE};

    // Straps are registered so readback never sees a pin mid-change
    bcs_sync #(.WIDTH(8)) u_opt  (.clk(CLOCK), .rst_n(RESET_N), .d(opt_raw),  .q(opt_q));
    bcs_sync #(.WIDTH(8)) u_jmp  (.clk(CLOCK), .rst_n(RESET_N), .d(JUMPER_HEADER_BITS),
                                  .q(jmp_q));
    bcs_sync #(.WIDTH(8)) u_dram (.clk(CLOCK), .rst_n(RESET_N), .d(dram_raw), .q(dram_q));
    bcs_sync #(.WIDTH(4)) u_cpu  (.clk(CLOCK), .rst_n(RESET_N), .d(cpu_raw),  .q(cpu_q));

    // Processor byte: kind code is constant, not from any strap
    // hard-wired kind
    always_comb begin
        proc_cfg = 8'h00;
        proc_cfg[BCS_KIND_LSB +: 4]  = BCS_PROC_KIND_CODE;
        proc_cfg[BCS_CLOCK_LSB +: 2] = cpu_q[3:2];
        proc_cfg[BCS_CACHE_LSB +: 2] = cpu_q[1:0];
    end

    // Byte decode of the four locations; unmapped addresses are not claimed
    // byte I/O decode
    always_comb begin
        rd_hit_d  = 1'b1;
        rd_data_d = BCS_IDLE_DATA;
        case (IO_ADDR)
            BCS_ADDR_PROC_CFG: begin
                rd_data_d = proc_cfg;
            end
            BCS_ADDR_JUMPERS: begin
                rd_data_d = jmp_q;
            end
            BCS_ADDR_BOARD_OPT: begin
                rd_data_d = opt_q;
            end
            BCS_ADDR_DRAM_SIZE: begin
                rd_data_d = dram_q;
            end
            default: begin
                rd_hit_d = 1'b0;
            end
        endcase
        // Reads only; a write strobe never drives the bus
        if (IO_READ_N) begin
            rd_hit_d = 1'b0;
        end
    end

    // Access state follows the read strobe to a mapped address
    always_comb begin
        case (state_q)
            BCS_IDLE: begin
                state_d = rd_hit_d ? BCS_READ : BCS_IDLE;
            end
            BCS_READ: begin
                state_d = rd_hit_d ? BCS_READ : BCS_IDLE;
            end
            default: begin
                state_d = BCS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= BCS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Registered read data; IO_WRITE_N is deliberately unused
    // writes have no effect
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            IO_DATA_OUT <= BCS_IDLE_DATA;
            IO_DATA_OE  <= 1'b0;
        end else begin
            IO_DATA_OUT <= rd_hit_d ? rd_data_d : BCS_IDLE_DATA;
            IO_DATA_OE  <= (state_d == BCS_READ);
        end
    end
endmodule

// file: sim/bcs_regs_chk.sv
`timescale 1ns/1ns
// Ties each read answer to its strobe and address, and the 0800 and 0801 bytes to their strap pins
module bcs_regs_chk
    import bcs_pkg::*;
(
    input wire logic        CLOCK,
    input wire logic        RESET_N,
    input wire logic [15:0] IO_ADDR,
    input wire logic        IO_READ_N,
    input wire logic [1:0]  SECOND_LEVEL_CACHE_SIZE,
    input wire logic [1:0]  CLOCK_RATIO_CODE,
    input wire logic [7:0]  JUMPER_HEADER_BITS,
    input wire logic [7:0]  IO_DATA_OUT,
    input wire logic        IO_DATA_OE
);
    logic hit;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    // Mapped read strobe; the 0803 hole is left out on purpose
    assign hit = !IO_READ_N && (IO_ADDR inside {16'h0800, 16'h0801, 16'h0802, 16'h0804});
    chk_oe_on_map: assert property (hit |=> IO_DATA_OE)
        else $error("mapped read gave no enable");
    chk_idle_quiet: assert property (!hit |=> !IO_DATA_OE && IO_DATA_OUT == 8'h00)
        else $error("unselected bus not quiet");
    chk_hole_refused: assert property (!IO_READ_N && IO_ADDR == 16'h0803 |=> !IO_DATA_OE)
        else $error("reserved byte answered");
    chk_kind_fixed: assert property (hit && IO_ADDR == 16'h0800 |=> IO_DATA_OUT[7:4] == BCS_PROC_KIND_CODE)
        else $error("processor kind wrong");
    // Strap copies need one edge after reset before they are trusted
    chk_proc_straps: assert property ($past(RESET_N) && hit && IO_ADDR == 16'h0800 |=>
        IO_DATA_OUT[3:0] == {$past(CLOCK_RATIO_CODE, 2), $past(SECOND_LEVEL_CACHE_SIZE, 2)})
        else $error("clock or cache field wrong");
    chk_jumper_byte: assert property ($past(RESET_N) && hit && IO_ADDR == 16'h0801 |=>
        IO_DATA_OUT == $past(JUMPER_HEADER_BITS, 2))
        else $error("jumper byte wrong");
    chk_spare_high: assert property (hit && IO_ADDR == 16'h0802 |=> IO_DATA_OUT[5])
        else $error("spare option bit low");
    chk_stand_two: assert property (hit [*2] |=> $past(IO_DATA_OE) && IO_DATA_OE)
        else $error("enable did not stand");
    cover property (hit && IO_ADDR == 16'h0804);
    cover property (hit [*2]);
    cover property (!IO_READ_N && IO_ADDR == 16'h0803);
endmodule
bind bcs_regs bcs_regs_chk u_chk (.*);

// file: sim/bcs_host.sv
`timescale 1ns/1ns
// Host end of the I/O bus; every call is one byte cycle launched at an edge
module bcs_host (
    input  wire logic        clk,
    output logic      [15:0] io_addr,
    output logic             io_read_n,
    output logic             io_write_n
);
    initial begin
        io_addr = 16'h0000;
        io_read_n = 1'b1;
        io_write_n = 1'b1;
    end
    task automatic cyc(input logic [15:0] a, input logic rd, input logic wr);
        @(posedge clk);
        io_addr <= a;
        io_read_n <= !rd;
        io_write_n <= !wr;
    endtask
endmodule

// file: sim/bcs_regs_tb_top.sv
`timescale 1ns/1ns
module bcs_regs_tb_top;
    import bcs_pkg::*;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic [15:0] io_addr;
    logic        io_read_n, io_write_n, io_data_oe;
    logic [1:0]  cache, clk_code;
    logic [7:0]  jumpers, opt, dram, io_data_out;
    logic [7:0]  exp_q[$];
    int          seed = 32'h61BB;
    int          bad_count = 0;
    int          tests_run = 0;
    always #2 clock = !clock;
    bcs_host host (.clk(clock), .io_addr(io_addr), .io_read_n(io_read_n),
        .io_write_n(io_write_n));
    bcs_regs uut (.CLOCK(clock), .RESET_N(reset_n), .IO_ADDR(io_addr),
        .IO_READ_N(io_read_n), .IO_WRITE_N(io_write_n), .SECOND_LEVEL_CACHE_SIZE(cache),
        .CLOCK_RATIO_CODE(clk_code), .JUMPER_HEADER_BITS(jumpers),
        .TRANSITION_MODULE_ABSENT(opt[7]), .SYNC_SERIAL_ABSENT(opt[6]),
        .MEZZANINE_CARD_ABSENT(opt[4]), .BACKPLANE_IF_ABSENT(opt[3]),
        .GRAPHICS_ABSENT(opt[2]), .NETWORK_ABSENT(opt[1]), .DISK_IF_ABSENT(opt[0]),
        .BANK_SIZE_CODE_LO(dram[2:0]), .REFRESH_FLAG_N_A_LO(dram[3]),
        .BANK_SIZE_CODE_HI(dram[6:4]), .REFRESH_FLAG_N_A_HI(dram[7]),
        .IO_DATA_OUT(io_data_out), .IO_DATA_OE(io_data_oe));
    task automatic check(input string name, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, e, s);
        end
    endtask
    task automatic wrap_up();
        if (bad_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Note the answer first, then launch the read
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.cyc(a, 1'b1, 1'b0);
    endtask
    // Mid-cycle sampling; an enable with no note pending is a stray answer
    always @(negedge clock) begin
        if (reset_n && io_data_oe === 1'b1)
            check("read data", exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, io_data_out);
        else if (reset_n)
            check("idle data", 8'h00, io_data_out);
    end
    initial begin
        {jumpers, opt, dram, cache, clk_code} = 28'hFFFFFFF;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            @(posedge clock);
            {jumpers, opt, dram, cache, clk_code} <= 28'($random(seed));
            // Straps settle for two edges while a write is thrown at the bank
            host.cyc(16'h0800, 1'b0, 1'b1);
            rd(16'h0800, {BCS_PROC_KIND_CODE, clk_code, cache});
            rd(16'h0801, jumpers);
            rd(16'h0802, {opt[7:6], 1'b1, opt[4:0]});
            host.cyc(16'h0803, 1'b1, 1'b0);
            rd(16'h0804, dram);
            host.cyc(16'hF7FB, 1'b0, 1'b0);
        end
        repeat (3) @(posedge clock);
        // A note left over means a read was never answered
        check("pending notes", 8'h00, 8'(exp_q.size()));
        wrap_up();
    end
endmodule
